// >>> rtl/dram_host.sv
// Host controller for a five-bit strobe-driven DRAM module: multiplexes
// row and column addresses, drives strobes and write enable, refreshes.
// Assumes the module's strobes, address and data-in are driven by this
// block and its data-out returns asynchronously on READ_DATA_OUTPUTS.
//
// Behaviour
// R1 - Module holds five parallel one-bit slices
// R2 - Nine row bits captured at row-strobe fall
// R3 - Nine column bits captured at column-strobe fall
// R4 - Address stable before its capturing strobe falls
// R5 - Row strobe enables sense amps and row
// R6 - Column strobe selects column and buffers
// R7 - Write enable high reads, low writes
// R8 - Reads ignore data inputs
// R9 - Early write keeps outputs high impedance
// R10 - Early write: data captured at column fall
// R11 - Delayed write: data captured at write fall
// R12 - Inputs latched, outputs unlatched
// R13 - Strobe all 256 rows each refresh period
// R14 - Column strobe high during row-only refresh
// R15 - Read data valid while column strobe low
// R16 - Column-before-row refresh uses internal counter
// R17 - Hidden refresh keeps read data valid
// R18 - Power-up pause then eight init cycles
// R19 - Refresh takes priority over access; a request granted in the cycle the refresh falls due still goes first
`default_nettype none
module dram_host
  import dram_host_pkg::*;
#(
  parameter int unsigned PAUSE_CYCLES = PAUSE_CYC,
  parameter int unsigned REFRESH_CYCLES = REF_PERIOD_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  // User request port
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_DELAYED,
  input wire logic [2*ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RESP_VALID,
  output logic [DATA_W-1:0] RESP_RDATA,
  output logic INIT_DONE,
  // Module pins
  output logic [ADDR_W-1:0] MUXED_ADDRESS_LINES,
  output logic ROW_STROBE_N,
  output logic COL_STROBE_N,
  output logic WRITE_ENABLE_N,
  output logic [DATA_W-1:0] WRITE_DATA_INPUTS,
  input wire logic [DATA_W-1:0] READ_DATA_OUTPUTS
);
  typedef struct packed {
    phase_e phase;
    logic [TIMER_W-1:0] timer;
    logic [3:0] init_left;
    logic write;
    logic delayed;
    logic [ADDR_W-1:0] col;
    logic [ADDR_W-1:0] addr;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [DATA_W-1:0] wdata;
    logic ready;
    logic resp;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic ref_ack;
  } host_s;
  host_s state_reg;
  host_s state_next;
  logic [DATA_W-1:0] rd_meta_reg;
  logic [DATA_W-1:0] rd_sync_reg;
  logic ref_req;

  // Load a phase timer with a cycle count
  function automatic logic [TIMER_W-1:0] cycles(input int unsigned n);
    cycles = TIMER_W'(n);
  endfunction

  // Per-row refresh pacing
  dram_refresh_timer #(
    .PERIOD(REFRESH_CYCLES)
  ) u_refresh (
    .clk(SYS_CLK),
    .rst(RESET),
    .ack(state_reg.ref_ack),
    .req(ref_req)
  );

  // Two-stage synchroniser on the asynchronous data-out pins
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rd_meta_reg <= '0;
      rd_sync_reg <= '0;
    end else begin
      rd_meta_reg <= READ_DATA_OUTPUTS; // R12
      rd_sync_reg <= rd_meta_reg;
    end
  end

  // Access, refresh and init sequencer
  always_comb begin
    state_next = state_reg;
    state_next.resp = 1'b0;
    state_next.ref_ack = 1'b0;
    state_next.ready = 1'b0;
    if (state_reg.timer != '0) begin
      state_next.timer = state_reg.timer - TIMER_ONE;
    end
    case (state_reg.phase)
      ST_PAUSE: begin
        if (state_reg.timer == '0) begin
          state_next.phase = ST_REFRESH; // R18
          state_next.cas_n = 1'b0; // R16
          state_next.timer = cycles(CSR_CYC);
        end
      end
      ST_IDLE: begin
        // Ready only after all init refreshes and while no refresh is due;
        // a request already granted is honoured, the refresh follows it
        state_next.ready = state_reg.done & ~ref_req & ~(REQ_VALID & state_reg.ready); // R19
        if (REQ_VALID && state_reg.ready) begin
          state_next.write = REQ_WRITE;
          state_next.delayed = REQ_DELAYED;
          state_next.col = REQ_ADDR[ADDR_W-1:0];
          state_next.addr = REQ_ADDR[2*ADDR_W-1:ADDR_W]; // R2 R4
          state_next.wdata = REQ_WDATA;
          state_next.phase = ST_ROW;
        end else if (ref_req || !state_reg.done) begin
          state_next.phase = ST_REFRESH; // R18 R19
          state_next.cas_n = 1'b0; // R16
          state_next.timer = cycles(CSR_CYC);
        end
      end
      ST_ROW: begin
        // Row address has been stable a cycle; drop row strobe
        state_next.ras_n = 1'b0; // R2 R5
        // Early write: enable low two or more cycles before the column strobe falls
        state_next.we_n = ~(state_reg.write & ~state_reg.delayed); // R7 R9 R10
        state_next.timer = cycles(RCD_CYC);
        state_next.phase = ST_COL;
      end
      ST_COL: begin
        if (state_reg.timer == '0 && state_reg.addr != state_reg.col) begin
          state_next.addr = state_reg.col; // R3 R4
        end else if (state_reg.timer == '0) begin
          state_next.cas_n = 1'b0; // R3 R6
          state_next.timer = cycles(CAS_CYC);
          state_next.phase = state_reg.write && state_reg.delayed ? ST_DWRITE : ST_CLOSE;
        end
      end
      ST_DWRITE: begin
        // Column strobe already low: write enable fall strobes data
        if (state_reg.timer == cycles(CAS_CYC - WP_CYC)) begin
          state_next.we_n = 1'b0; // R11
          state_next.phase = ST_CLOSE;
        end
      end
      ST_CLOSE: begin
        if (state_reg.timer == '0) begin
          // Sample read data while the column strobe is still low
          if (!state_reg.write) begin
            state_next.rdata = rd_sync_reg; // R8 R15
          end
          state_next.resp = 1'b1;
          state_next.ras_n = 1'b1;
          // Column strobe released with the row: no hidden or row-only refresh
          state_next.cas_n = 1'b1; // R14 R17
          state_next.we_n = 1'b1;
          state_next.timer = cycles(RP_CYC);
          state_next.phase = ST_PRECH;
        end
      end
      ST_PRECH: begin
        if (state_reg.timer == '0) begin
          state_next.phase = ST_IDLE;
        end
      end
      ST_REFRESH: begin
        // Column strobe led the row strobe; internal counter picks the row
        if (state_reg.timer == '0 && state_reg.ras_n) begin
          state_next.ras_n = 1'b0; // R13 R16
          state_next.timer = cycles(RAS_CYC);
        end else if (state_reg.timer == '0) begin
          state_next.ras_n = 1'b1;
          state_next.cas_n = 1'b1;
          state_next.ref_ack = 1'b1; // R13
          state_next.timer = cycles(RP_CYC);
          if (state_reg.init_left != '0) begin
            state_next.init_left = state_reg.init_left - 4'h1; // R18
          end
          state_next.done = state_reg.done | (state_reg.init_left == 4'h1);
          state_next.phase = ST_PRECH;
        end
      end
      default: begin
        state_next.phase = ST_IDLE;
      end
    endcase
  end

  // Register the whole controller state
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_reg <= '0;
      state_reg.phase <= ST_PAUSE;
      state_reg.timer <= TIMER_W'(PAUSE_CYCLES); // R18
      state_reg.init_left <= INIT_COUNT;
      state_reg.ras_n <= 1'b1;
      state_reg.cas_n <= 1'b1;
      state_reg.we_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flip-flops
  assign MUXED_ADDRESS_LINES = state_reg.addr;
  assign ROW_STROBE_N = state_reg.ras_n;
  assign COL_STROBE_N = state_reg.cas_n;
  assign WRITE_ENABLE_N = state_reg.we_n;
  assign WRITE_DATA_INPUTS = state_reg.wdata;
  assign REQ_READY = state_reg.ready;
  assign RESP_VALID = state_reg.resp;
  assign RESP_RDATA = state_reg.rdata;
  assign INIT_DONE = state_reg.done;
endmodule
`default_nettype wire

// >>> rtl/dram_host_pkg.sv
// Constants and types for the five-bit strobe-driven DRAM module controller.
// Assumes a 25 MHz system clock; all strobe timing is counted in its cycles.
`default_nettype none
package dram_host_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 5;
  localparam int unsigned ROW_COUNT = 256;
  localparam int unsigned ROW_W = 8;
  // Strobe timing in ns (refresh in ms, pause in us), slowest speed grade
  localparam int unsigned T_RP_NS = 120;
  localparam int unsigned T_RCD_NS = 30;
  localparam int unsigned T_CAS_NS = 100;
  localparam int unsigned T_RSH_NS = 100;
  localparam int unsigned T_RAS_NS = 200;
  localparam int unsigned T_ACC_NS = 200;
  localparam int unsigned T_WP_NS = 55;
  localparam int unsigned T_CSR_NS = 35;
  localparam int unsigned T_REF_MS = 4;
  localparam int unsigned T_PAUSE_US = 200;
  localparam int unsigned INIT_CYCLES = 8;
  // Derived cycle counts, least times rounded up
  localparam int unsigned RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CAS_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RAS_CYC = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CSR_CYC = (T_CSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Refresh interval per row, rounded down (longest time)
  localparam int unsigned REF_PERIOD_CYC = (T_REF_MS * 1000000 / CLK_PERIOD_NS) / ROW_COUNT;
  localparam int unsigned PAUSE_CYC = (T_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 16;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 16'h0001;
  localparam logic [3:0] INIT_COUNT = 4'h8;

  typedef enum logic [3:0] {
    ST_PAUSE = 4'h0,
    ST_IDLE = 4'h1,
    ST_ROW = 4'h2,
    ST_COL = 4'h3,
    ST_DWRITE = 4'h4,
    ST_CLOSE = 4'h5,
    ST_PRECH = 4'h6,
    ST_REFRESH = 4'h7
  } phase_e;
endpackage
`default_nettype wire

// >>> rtl/dram_refresh_timer.sv
// Refresh request generator: raises a request each per-row refresh interval.
// Assumes the controller acknowledges with a one-cycle pulse per refreshed row.
`default_nettype none
module dram_refresh_timer
  import dram_host_pkg::*;
#(
  parameter int unsigned PERIOD = REF_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ack,
  output logic req
);
  typedef struct packed {
    logic [TIMER_W-1:0] count;
    logic req;
  } timer_s;
  timer_s state_reg;
  timer_s state_next;

  // Count down; a new expiry wins over the acknowledge of the old one
  always_comb begin
    state_next = state_reg;
    if (ack) begin
      state_next.req = 1'b0;
    end
    if (state_reg.count == '0) begin
      state_next.count = TIMER_W'(PERIOD - 1);
      state_next.req = 1'b1;
    end else begin
      state_next.count = state_reg.count - TIMER_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign req = state_reg.req;
endmodule
`default_nettype wire

// >>> tb/dram_host_assertions.sv
// Strobe protocol checker for the DRAM host controller.
// Sees only the top module's ports; bound after the module.
`default_nettype none
module dram_host_assertions
  import dram_host_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic [2*ADDR_W-1:0] REQ_ADDR,
  input wire logic RESP_VALID,
  input wire logic INIT_DONE,
  input wire logic [ADDR_W-1:0] MUXED_ADDRESS_LINES,
  input wire logic ROW_STROBE_N,
  input wire logic COL_STROBE_N,
  input wire logic WRITE_ENABLE_N
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2*ADDR_W-1:0] held_addr;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // Address of the last request taken
  always_ff @(posedge SYS_CLK) if (REQ_VALID && REQ_READY) held_addr <= REQ_ADDR;
  reset_idle_a: assert property ($fell(RESET) |-> ROW_STROBE_N && COL_STROBE_N && !INIT_DONE)
    else $error("strobes busy after reset");
  ready_init_a: assert property (REQ_READY |-> INIT_DONE) else $error("ready before init");
  take_row_a: assert property (REQ_VALID && REQ_READY |-> ##[1:3] $fell(ROW_STROBE_N))
    else $error("no row strobe");
  row_addr_a: assert property ($fell(ROW_STROBE_N) && COL_STROBE_N |->
    MUXED_ADDRESS_LINES == held_addr[17:9]) else $error("bad row address");
  col_addr_a: assert property ($fell(COL_STROBE_N) && !ROW_STROBE_N |->
    MUXED_ADDRESS_LINES == held_addr[8:0] && $stable(MUXED_ADDRESS_LINES))
    else $error("bad column address");
  ras_width_a: assert property ($fell(ROW_STROBE_N) |-> (!ROW_STROBE_N)[*5])
    else $error("row strobe short");
  precharge_a: assert property ($rose(ROW_STROBE_N) |-> ROW_STROBE_N[*3])
    else $error("precharge short");
  cbr_order_a: assert property ($fell(ROW_STROBE_N) && !COL_STROBE_N |->
    !$past(COL_STROBE_N) ##0 (!COL_STROBE_N)[*5]) else $error("refresh order");
  we_row_a: assert property ($fell(WRITE_ENABLE_N) |-> !ROW_STROBE_N)
    else $error("write outside row");
  resp_pulse_a: assert property (RESP_VALID |=> !RESP_VALID) else $error("long response");
endmodule
bind dram_host dram_host_assertions chk (.SYS_CLK, .RESET, .REQ_VALID, .REQ_READY,
  .REQ_ADDR, .RESP_VALID, .INIT_DONE, .MUXED_ADDRESS_LINES, .ROW_STROBE_N,
  .COL_STROBE_N, .WRITE_ENABLE_N);
`default_nettype wire

// >>> tb/dram_module_model.sv
// Behavioural five-slice DRAM module answering the host's strobes.
// Assumes strobes, address and data-in come straight from the host.
`default_nettype none
module dram_module_model
  import dram_host_pkg::*;
(
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout,
  output logic [15:0] ref_count,
  output logic [15:0] bad_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [logic [2*ADDR_W-1:0]];
  logic [ADDR_W-1:0] row;
  logic [ADDR_W-1:0] col;
  logic cbr;
  logic rd_on;
  initial begin
    ref_count = '0;
    bad_count = '0;
    cbr = 1'b0;
    rd_on = 1'b0;
    dout = '0;
  end
  // Row capture, or internal-counter refresh when the column strobe leads
  always @(negedge ras_n) begin
    cbr = !cas_n;
    if (cbr) ref_count = ref_count + 16'h1;
    else row = addr;
    if (!cbr && ref_count < INIT_CYCLES) bad_count = bad_count + 16'h1;
  end
  // Column capture; early write stores here with outputs left off
  always @(negedge cas_n) begin
    if (!ras_n && !cbr) begin
      col = addr;
      if (!we_n) mem[{row, col}] = din;
      else #(T_CAS_NS) rd_on = !cas_n;
    end
  end
  // Delayed write stores at the write strobe fall
  always @(negedge we_n) if (!ras_n && !cas_n && !cbr) mem[{row, col}] = din;
  // Outputs turn off when the column strobe rises
  always @(posedge cas_n) rd_on = 1'b0;
  // Off state shows the inverse of the last value, not a held copy
  always @(rd_on) dout = rd_on ? mem[{row, col}] : ~dout;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Testbench: drives the user port, checks data and refresh via the model.
// Assumes the checker and the module model are compiled beforehand.
`default_nettype none
module tb
  import dram_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK, RESET, REQ_VALID, REQ_WRITE, REQ_DELAYED, REQ_READY, RESP_VALID, INIT_DONE;
  logic ROW_STROBE_N, COL_STROBE_N, WRITE_ENABLE_N;
  logic [17:0] REQ_ADDR;
  logic [8:0] MUXED_ADDRESS_LINES;
  logic [4:0] REQ_WDATA, RESP_RDATA, WRITE_DATA_INPUTS, READ_DATA_OUTPUTS, q;
  logic [15:0] ref_count, bad_count;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  dram_host #(.PAUSE_CYCLES(20), .REFRESH_CYCLES(50)) uut (.SYS_CLK, .RESET, .REQ_VALID,
    .REQ_WRITE, .REQ_DELAYED, .REQ_ADDR, .REQ_WDATA, .REQ_READY, .RESP_VALID, .RESP_RDATA,
    .INIT_DONE, .MUXED_ADDRESS_LINES, .ROW_STROBE_N, .COL_STROBE_N, .WRITE_ENABLE_N,
    .WRITE_DATA_INPUTS, .READ_DATA_OUTPUTS);
  dram_module_model mem_model (.ras_n(ROW_STROBE_N), .cas_n(COL_STROBE_N),
    .we_n(WRITE_ENABLE_N), .addr(MUXED_ADDRESS_LINES), .din(WRITE_DATA_INPUTS),
    .dout(READ_DATA_OUTPUTS), .ref_count, .bad_count);
  // Clock and cycle count
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) cyc <= cyc + 1;
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One access: hold the request until taken, then wait for the response
  task automatic access(input logic wr, input logic dl, input logic [17:0] a,
    input logic [4:0] d);
    int n;
    REQ_WRITE <= wr;
    REQ_DELAYED <= dl;
    REQ_ADDR <= a;
    REQ_WDATA <= d;
    REQ_VALID <= 1'b1;
    n = 0;
    do begin @(posedge SYS_CLK); n++; end while (REQ_READY !== 1'b1 && n < 500);
    check("req_taken", 16'h1, {15'h0, REQ_READY === 1'b1});
    REQ_VALID <= 1'b0;
    n = 0;
    do begin @(posedge SYS_CLK); n++; end while (RESP_VALID !== 1'b1 && n < 60);
    check("resp_seen", 16'h1, {15'h0, RESP_VALID === 1'b1});
    q = RESP_RDATA;
  endtask
  task automatic test_init;
    int n;
    n = 0;
    while (INIT_DONE !== 1'b1 && n < 400) begin @(posedge SYS_CLK); n++; end
    check("init_done", 16'h1, {15'h0, INIT_DONE});
    check("init_refresh", 16'h1, {15'h0, ref_count >= 16'h8});
  endtask
  // Both write kinds at corner and row/column-neighbour addresses
  task automatic test_write_read;
    logic [17:0] a [4] = '{18'h3ffff, 18'h00000, 18'h00200, 18'h00001};
    logic [4:0] d [4] = '{5'h15, 5'h0a, 5'h03, 5'h1c};
    for (int i = 0; i < 4; i++) access(1'b1, i[0], a[i], d[i]);
    for (int i = 0; i < 4; i++) begin
      access(1'b0, 1'b0, a[i], 5'h1f);
      check("read_data", {11'h0, d[i]}, {11'h0, q});
    end
  endtask
  // Steady reads must still let refresh keep its rate
  task automatic test_refresh_load;
    logic [15:0] r0;
    int c0;
    r0 = ref_count;
    c0 = cyc;
    for (int i = 0; i < 24; i++) access(1'b0, 1'b0, 18'h3ffff, 5'h00);
    check("refresh_rate", 16'h1, {15'h0, int'(ref_count - r0) >= (cyc - c0) / 50 - 1});
    check("read_repeat", 16'h15, {11'h0, q});
    check("early_access", 16'h0, bad_count);
  endtask
  initial begin
    RESET = 1'b1;
    REQ_VALID = 1'b0;
    REQ_WRITE = 1'b0;
    REQ_DELAYED = 1'b0;
    REQ_ADDR = '0;
    REQ_WDATA = '0;
    repeat (6) @(posedge SYS_CLK);
    RESET <= 1'b0;
    test_init;
    test_write_read;
    test_refresh_load;
    final_report;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    miscompares++;
    final_report;
  end
endmodule
`default_nettype wire
